// *** rtl/smidc_ctrl.v ***
// smidc_ctrl.v: lower half of a serial channel control register a, with modem
// outputs, per-condition interrupt enables, dma request gating and the channel
// enable / receive-handshake bits they interact with.
// assumes a wishbone classic master on ref_clk and status events as pulses.
//
// Function
// RL1: the terminal-ready bit at 17 drives the terminal-ready output active when 1 and inactive when 0.
// RL2: the request-to-send bit at 16 drives the request-to-send output active when 1 and inactive when 0.
// RL3: each enable bit lets its status bit raise the interrupt when 1 and blocks it when 0.
// RL4: receive enables sit at bits 15..9: break, framing, parity, overrun, ready, fifo half, buffer closed.
// RL5: modem change enables sit at bit 7 carrier, 6 ring, 5 set-ready, 4 clear-to-send.
// RL6: transmit enables sit at bit 3 register empty, 2 fifo half-empty, 1 buffer closed.
// RL7: with the receive dma bit at 8 set the receiver requests dma to drain its fifo.
// RL8: in receive dma operation the receive status is moved into the buffer descriptor by hardware.
// RL9: clearing the receive dma bit pauses the receiver and stops its requests.
// RL10: with the transmit dma bit at 0 set the transmitter requests dma to fill its fifo.
// RL11: clearing the transmit dma bit pauses the transmitter and stops its requests.
// RL12: while the channel enable bit at 31 is 0 the port and both fifos are held in reset.
// RL13: with receive handshake at bit 22 set, request-to-send follows fifo room and drops on almost full.
// RL14: the interrupt output is the or of all set and enabled status bits and falls when none remain.
// RL15: all modem, interrupt-enable and dma-enable bits reset to zero.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smidc_defines.vh"
module smidc_ctrl
(
  input wire ref_clk,
  input wire reset,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [31:0] status_event_i,
  input wire rx_fifo_have_data_i,
  input wire rx_fifo_almost_full_i,
  input wire tx_fifo_has_room_i,
  input wire rx_desc_busy_i,
  output reg dtr_n_o,
  output reg rts_n_o,
  output reg port_reset_o,
  output reg rx_run_o,
  output reg tx_run_o,
  output reg rx_dma_req_o,
  output reg tx_dma_req_o,
  output reg rx_status_to_desc_o,
  output reg irq_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] serial_channel_control_a_r;
  reg [31:0] status_r;
  reg [31:0] status_nxt;
  reg [31:0] ctrl_nxt;
  wire [31:0] byte_mask;
  wire wr_stb;
  wire rd_stb;
  wire chan_en;
  wire rx_dma_request_enable;
  wire tx_dma_request_enable;
  wire rx_flow_handshake_enable;
  reg [31:0] irq_enable_field;
  wire [31:0] irq_pending;
  wire hit_ctrl;
  wire hit_status;
  wire rx_break_irq_en;
  wire rx_framing_irq_en;
  wire rx_parity_irq_en;
  wire rx_overrun_irq_en;
  wire rx_ready_irq_en;
  wire rx_fifo_half_irq_en;
  wire buffer_closed_irq_en;
  wire carrier_change_irq_en;
  wire ring_change_irq_en;
  wire set_ready_change_irq_en;
  wire clear_to_send_change_irq_en;
  wire tx_empty_irq_en;
  wire tx_fifo_half_irq_en;
  wire tx_closed_irq_en;

  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // ack is dropped for one cycle after each answer so a held strobe is not taken twice
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign hit_ctrl = (wb_adr_i == `SMIDC_OFS_CTRL_A);
  assign hit_status = (wb_adr_i == `SMIDC_OFS_STATUS);
  // decoded from the next value, so run, request and reset outputs all move at
  // the edge that acks the write and never disagree for a cycle
  assign chan_en = ctrl_nxt[`SMIDC_BIT_CHAN_EN];
  assign rx_dma_request_enable = ctrl_nxt[`SMIDC_BIT_RX_DMA];
  assign tx_dma_request_enable = ctrl_nxt[`SMIDC_BIT_TX_DMA];
  assign rx_flow_handshake_enable = ctrl_nxt[`SMIDC_BIT_RX_FLOW];

  // ----------------------------------------------------------------
  // per-condition interrupt enables
  // ----------------------------------------------------------------
  // a new mask applies from the cycle after its write is acked
  assign rx_break_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_BREAK];
  assign rx_framing_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_FRAMING];
  assign rx_parity_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_PARITY];
  assign rx_overrun_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_OVERRUN];
  assign rx_ready_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_READY];
  assign rx_fifo_half_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_HALF];
  assign buffer_closed_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RX_CLOSED];
  assign carrier_change_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_CARRIER];
  assign ring_change_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_RING];
  assign set_ready_change_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_SET_READY];
  assign clear_to_send_change_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_CLEAR_SEND];
  assign tx_empty_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_TX_EMPTY];
  assign tx_fifo_half_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_TX_HALF];
  assign tx_closed_irq_en = serial_channel_control_a_r[`SMIDC_BIT_IE_TX_CLOSED];

  // enable bits sit at the same positions as their status bits
  always @*
  begin
    irq_enable_field = 32'h00000000;
    irq_enable_field[`SMIDC_BIT_IE_RX_BREAK] = rx_break_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_RX_FRAMING] = rx_framing_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_RX_PARITY] = rx_parity_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_RX_OVERRUN] = rx_overrun_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_RX_READY] = rx_ready_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_RX_HALF] = rx_fifo_half_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_RX_CLOSED] = buffer_closed_irq_en; // RL4
    irq_enable_field[`SMIDC_BIT_IE_CARRIER] = carrier_change_irq_en; // RL5
    irq_enable_field[`SMIDC_BIT_IE_RING] = ring_change_irq_en; // RL5
    irq_enable_field[`SMIDC_BIT_IE_SET_READY] = set_ready_change_irq_en; // RL5
    irq_enable_field[`SMIDC_BIT_IE_CLEAR_SEND] = clear_to_send_change_irq_en; // RL5
    irq_enable_field[`SMIDC_BIT_IE_TX_EMPTY] = tx_empty_irq_en; // RL6
    irq_enable_field[`SMIDC_BIT_IE_TX_HALF] = tx_fifo_half_irq_en; // RL6
    irq_enable_field[`SMIDC_BIT_IE_TX_CLOSED] = tx_closed_irq_en; // RL6
  end

  assign irq_pending = status_nxt & irq_enable_field; // RL3

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always @*
  begin
    ctrl_nxt = serial_channel_control_a_r;
    if (wr_stb && hit_ctrl)
    begin
      ctrl_nxt = (serial_channel_control_a_r & ~(byte_mask & `SMIDC_CTRL_WMASK)) |
                 (wb_dat_i & byte_mask & `SMIDC_CTRL_WMASK);
    end
  end

  always @*
  begin
    status_nxt = status_r;
    if (wr_stb && hit_status)
    begin
      status_nxt = status_r & ~(wb_dat_i & byte_mask);
    end
    // a new event wins over a write-one-to-clear in the same cycle
    status_nxt = (status_nxt | status_event_i) & `SMIDC_IRQ_MASK;
  end

  // ----------------------------------------------------------------
  // register bus and state
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      serial_channel_control_a_r <= `SMIDC_CTRL_RESET; // RL15
      status_r <= `SMIDC_STAT_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      serial_channel_control_a_r <= ctrl_nxt;
      status_r <= status_nxt;
      wb_ack_o <= wr_stb | rd_stb;
      if (rd_stb)
      begin
        case (wb_adr_i)
          `SMIDC_OFS_CTRL_A: wb_dat_o <= serial_channel_control_a_r;
          `SMIDC_OFS_STATUS: wb_dat_o <= status_r;
          `SMIDC_OFS_FEED: wb_dat_o <= {30'h00000000, tx_fifo_has_room_i, rx_fifo_have_data_i};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      else
      begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // modem, dma and interrupt outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      dtr_n_o <= 1'b1;
      rts_n_o <= 1'b1;
      port_reset_o <= 1'b1;
      rx_run_o <= 1'b0;
      tx_run_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
      rx_status_to_desc_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      dtr_n_o <= ~ctrl_nxt[`SMIDC_BIT_DTR]; // RL1
      if (rx_flow_handshake_enable)
      begin
        // flow control: drop rts while the receive fifo is almost full
        rts_n_o <= rx_fifo_almost_full_i; // RL13
      end
      else
      begin
        rts_n_o <= ~ctrl_nxt[`SMIDC_BIT_RTS]; // RL2
      end
      port_reset_o <= ~chan_en; // RL12
      rx_run_o <= chan_en & rx_dma_request_enable; // RL9
      tx_run_o <= chan_en & tx_dma_request_enable; // RL11
      rx_dma_req_o <= chan_en & rx_dma_request_enable & rx_fifo_have_data_i; // RL7 RL9
      tx_dma_req_o <= chan_en & tx_dma_request_enable & tx_fifo_has_room_i; // RL10 RL11
      // descriptor status hand-off only while the receive dma path runs
      rx_status_to_desc_o <= chan_en & rx_dma_request_enable & rx_desc_busy_i; // RL8
      irq_o <= |irq_pending; // RL3 RL14
    end
  end
endmodule
`default_nettype wire

// *** rtl/smidc_defines.vh ***
// smidc_defines.vh: register map, field positions and reset values of the serial
// modem, interrupt-enable and dma-request control block.
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
`ifndef SMIDC_DEFINES_VH
`define SMIDC_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SMIDC_OFS_CTRL_A 8'h00
`define SMIDC_OFS_STATUS 8'h04
`define SMIDC_OFS_FEED 8'h08
// ----------------------------------------------------------------
// control register a fields
// ----------------------------------------------------------------
`define SMIDC_BIT_CHAN_EN 31
`define SMIDC_BIT_RX_FLOW 22
`define SMIDC_BIT_DTR 17
`define SMIDC_BIT_RTS 16
`define SMIDC_BIT_RX_DMA 8
`define SMIDC_BIT_TX_DMA 0
`define SMIDC_CTRL_WMASK 32'h80C3FFFF
`define SMIDC_CTRL_RESET 32'h00000000
// ----------------------------------------------------------------
// interrupt enable positions, shared with their status bits
// ----------------------------------------------------------------
`define SMIDC_BIT_IE_RX_BREAK 15
`define SMIDC_BIT_IE_RX_FRAMING 14
`define SMIDC_BIT_IE_RX_PARITY 13
`define SMIDC_BIT_IE_RX_OVERRUN 12
`define SMIDC_BIT_IE_RX_READY 11
`define SMIDC_BIT_IE_RX_HALF 10
`define SMIDC_BIT_IE_RX_CLOSED 9
`define SMIDC_BIT_IE_CARRIER 7
`define SMIDC_BIT_IE_RING 6
`define SMIDC_BIT_IE_SET_READY 5
`define SMIDC_BIT_IE_CLEAR_SEND 4
`define SMIDC_BIT_IE_TX_EMPTY 3
`define SMIDC_BIT_IE_TX_HALF 2
`define SMIDC_BIT_IE_TX_CLOSED 1
// ----------------------------------------------------------------
// status / irq enable layout: bits 15..9, 7..1 hold conditions
// ----------------------------------------------------------------
`define SMIDC_IRQ_MASK 32'h0000FEFE
`define SMIDC_STAT_RESET 32'h00000000
// feed register fields: dma-side readiness reported by the shift engine
`define SMIDC_BIT_RX_HAVE 0
`define SMIDC_BIT_TX_ROOM 1
`endif

// *** tb/smidc_properties.sv ***
// smidc_properties.sv: port checks of the control block.
// assumes one clock, reset synchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module smidc_properties (
  input wire ref_clk, reset, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire dtr_n_o, rts_n_o, port_reset_o, rx_run_o, tx_run_o,
  input wire rx_dma_req_o, tx_dma_req_o, rx_status_to_desc_o, irq_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire wr_c = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  dtr_write_a: assert property (wb_ack_o && $past(wr_c && wb_sel_i[2])
    |-> dtr_n_o == !$past(wb_dat_i[17])) else $error("terminal ready wrong");
  rts_write_a: assert property (wb_ack_o && $past(wr_c && wb_sel_i[2] && !wb_dat_i[22])
    |-> rts_n_o == !$past(wb_dat_i[16])) else $error("request to send wrong");
  rx_pause_a: assert property (wb_ack_o && $past(wr_c && wb_sel_i[1] && !wb_dat_i[8])
    |-> !rx_run_o && !rx_dma_req_o) else $error("receiver not paused");
  tx_pause_a: assert property (wb_ack_o && $past(wr_c && wb_sel_i[0] && !wb_dat_i[0])
    |-> !tx_run_o && !tx_dma_req_o) else $error("transmitter not paused");
  rx_gate_a: assert property (rx_dma_req_o |-> rx_run_o)
    else $error("receive request while stopped");
  tx_gate_a: assert property (tx_dma_req_o |-> tx_run_o)
    else $error("transmit request while stopped");
  desc_gate_a: assert property (rx_status_to_desc_o |-> rx_run_o)
    else $error("descriptor hand-off while stopped");
  port_hold_a: assert property (port_reset_o |-> !rx_run_o && !tx_run_o)
    else $error("path runs while port held");
  reset_value_a: assert property ($fell(reset) |-> dtr_n_o && rts_n_o && !irq_o)
    else $error("outputs not idle after reset");
  cover property (rx_dma_req_o);
  cover property (tx_dma_req_o);
  cover property ($rose(irq_o));
  cover property (rx_status_to_desc_o);
endmodule
bind smidc_ctrl smidc_properties smidc_properties_inst (.*);
`default_nettype wire

// *** tb/smidc_partner.sv ***
// smidc_partner.sv: shift engine and line side, small fifos.
// assumes dma requests drain one receive byte a cycle.
`timescale 1ns/1ps
`default_nettype none
module smidc_partner (
  input wire ref_clk, port_reset, rx_dma_req, tx_dma_req, rx_put,
  output wire rx_have, rx_almost_full, tx_room, desc_busy
);
  logic [2:0] rx_cnt, tx_cnt;
  assign rx_have = rx_cnt != 3'h0;
  assign rx_almost_full = rx_cnt >= 3'h6;
  assign tx_room = tx_cnt < 3'h4;
  // receive status waits for a descriptor while bytes are held
  assign desc_busy = rx_have;
  // the transmit fifo never drains, so room must run out
  always @(posedge ref_clk)
  begin
    rx_cnt <= port_reset ? 3'h0 : rx_cnt + {2'h0, rx_put} - {2'h0, rx_dma_req & rx_have};
    tx_cnt <= port_reset ? 3'h0 : tx_cnt + {2'h0, tx_dma_req & tx_room};
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// tb.sv: bus tests of the control block with its line partner.
// assumes ack one cycle after a request is taken.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 0, reset = 1, we = 0, cyc = 0, stb = 0, rx_put = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, ev = 32'h0, rdat;
  wire [31:0] dat_o;
  wire ack, dtr_n, rts_n, prst, rx_run, tx_run, rx_req, tx_req, irq, have, af, room, busy, desc;
  int miscompares = 0, n_compared = 0, n;
  smidc_ctrl smidc_ctrl_inst (.ref_clk(ref_clk), .reset(reset), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .status_event_i(ev), .rx_fifo_have_data_i(have),
    .rx_fifo_almost_full_i(af), .tx_fifo_has_room_i(room), .rx_desc_busy_i(busy),
    .dtr_n_o(dtr_n), .rts_n_o(rts_n), .port_reset_o(prst), .rx_run_o(rx_run),
    .tx_run_o(tx_run), .rx_dma_req_o(rx_req), .tx_dma_req_o(tx_req),
    .rx_status_to_desc_o(desc), .irq_o(irq));
  smidc_partner smidc_partner_inst (.ref_clk(ref_clk), .port_reset(prst),
    .rx_dma_req(rx_req), .tx_dma_req(tx_req), .rx_put(rx_put), .rx_have(have),
    .rx_almost_full(af), .tx_room(room), .desc_busy(busy));
  initial forever #5 ref_clk = ~ref_clk;
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task xfer(input [7:0] a, input [31:0] d, input w);
    @(posedge ref_clk);
    {adr, dat, we, cyc, stb} <= {a, d, w, 2'b11};
    n = 0;
    do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50)
    begin
      miscompares++;
      give_verdict;
    end
    else {we, cyc, stb} <= 3'b000;
  endtask
  task pulse(input int i);
    @(posedge ref_clk); ev <= 32'h1 << i;
    @(posedge ref_clk); ev <= 32'h0;
    repeat (2) @(posedge ref_clk); #1;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk); reset <= 0;
    xfer(8'h00, 0, 0); chk("ctrl", 0, rdat);
    chk("outs", 6'h38, {dtr_n, rts_n, prst, irq, rx_run, tx_run});
    xfer(8'h00, 32'h00030000, 1); #1 chk("modem", 3'h1, {dtr_n, rts_n, prst});
    xfer(8'h00, 32'h00010000, 1); #1 chk("rts only", 3'h5, {dtr_n, rts_n, prst});
    xfer(8'h00, 32'h00020000, 1); #1 chk("dtr only", 3'h3, {dtr_n, rts_n, prst});
    xfer(8'h00, 32'hFFFFFFFF, 1); xfer(8'h00, 0, 0); chk("ctrl", 32'h80C3FFFF, rdat);
    xfer(8'h0C, 32'hFFFFFFFF, 1); xfer(8'h0C, 0, 0); chk("unmapped", 0, rdat);
    $display("test modem and map done");
    for (int i = 1; i < 16; i++)
      if (i != 8)
      begin
        xfer(8'h00, 32'h80000000 | (32'h1 << i), 1); pulse(i); chk("irq on", 1, irq);
        xfer(8'h04, 0, 0); chk("status", 32'h1 << i, rdat);
        xfer(8'h04, 32'h1 << i, 1); #1 chk("irq off", 0, irq);
        xfer(8'h00, 32'h8000FEFE ^ (32'h1 << i), 1); pulse(i); chk("irq masked", 0, irq);
        xfer(8'h04, 32'h1 << i, 1);
      end
    $display("test interrupts done");
    xfer(8'h00, 0, 1);
    xfer(8'h00, 32'h80400000, 1);
    repeat (6) begin @(posedge ref_clk); rx_put <= 1; @(posedge ref_clk); rx_put <= 0; end
    @(posedge ref_clk); #1 chk("rts full", 1, rts_n);
    chk("no rx req", 2'h0, {rx_req, desc});
    xfer(8'h08, 0, 0); chk("feed", 32'h3, rdat);
    xfer(8'h00, 32'h80400101, 1); #1 chk("runs", 3'h7, {rx_run, tx_run, desc});
    n = 0;
    while ((have !== 1'b0 || room !== 1'b0) && n < 50) begin @(posedge ref_clk); n++; end
    if (n >= 50)
    begin
      miscompares++;
      give_verdict;
    end
    @(posedge ref_clk); #1 chk("drained", 4'h0, {rts_n, have, room, desc});
    xfer(8'h00, 32'h80400000, 1); #1 chk("paused", 4'h0, {rx_run, tx_run, rx_req, tx_req});
    xfer(8'h00, 0, 1); #1 chk("port held", 1, prst);
    $display("test dma and handshake done");
    give_verdict;
  end
endmodule
`default_nettype wire
